//--- rtl/qlcd_pkg.sv
// Package for the quadruplex LCD waveform sequencer: register map, fields, timing
package qlcd_pkg;
  localparam int QLCD_SEGS = 32;
  localparam int QLCD_COMS = 4;
  localparam int QLCD_ADDR_W = 6;
  // Register byte offsets
  localparam logic [5:0] QLCD_CTRL_OFS = 6'h00;
  localparam logic [5:0] QLCD_ACTIVE_OFS = 6'h04;
  localparam logic [5:0] QLCD_DEAD_OFS = 6'h08;
  localparam logic [5:0] QLCD_STATUS_OFS = 6'h0C;
  localparam logic [5:0] QLCD_SEG0_OFS = 6'h10;
  // Control fields
  localparam int QLCD_CTRL_EN_BIT = 0;
  localparam int QLCD_CTRL_INC_BIT = 1;
  localparam int QLCD_CTRL_EOF_BIT = 2;
  // Reset values and bus response codes
  localparam logic [15:0] QLCD_ACTIVE_RST = 16'h03E8;
  localparam logic [15:0] QLCD_DEAD_RST = 16'h0000;
  localparam logic [1:0] QLCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] QLCD_RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    QLCD_ACT1,
    QLCD_DEAD1,
    QLCD_ACT2,
    QLCD_DEAD2
  } qlcd_part_t;

  typedef struct packed {
    logic enable;
    logic rms_increase;
    logic dead_at_frame_end;
    logic [15:0] active_len;
    logic [15:0] dead_len;
    logic [QLCD_SEGS*QLCD_COMS-1:0] seg_data;
  } qlcd_cfg_t;

  typedef struct packed {
    logic [QLCD_SEGS-1:0] seg;
    logic [QLCD_COMS-1:0] com_out;
    logic [QLCD_COMS-1:0] com_oe;
  } qlcd_pins_t;
endpackage : qlcd_pkg

//--- rtl/qlcd_axil_regs.sv
// AXI4-Lite register slave for the quadruplex LCD waveform sequencer
`timescale 1ns/100ps
module qlcd_axil_regs
  import qlcd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [qlcd_pkg::QLCD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [qlcd_pkg::QLCD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [7:0] status,
  output qlcd_pkg::qlcd_cfg_t cfg
);
  import qlcd_pkg::*;

  logic [5:0] aw_addr;
  logic aw_have;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_have;
  logic do_wr;
  logic wr_hit;
  logic [31:0] regs [0:7];
  logic [31:0] rd_val;
  logic rd_hit;

  assign do_wr = aw_have && w_have && !s_axi_bvalid;
  assign wr_hit = aw_addr[5:2] < 4'h8 && aw_addr[5:2] != 4'h3;
  assign s_axi_awready = !aw_have;
  assign s_axi_wready = !w_have;

  // Address and data taken in either order, held until both present
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      aw_have <= 1'b0;
      aw_addr <= 6'h00;
    end else if (s_axi_awvalid && !aw_have) begin
      aw_have <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_wr) begin
      aw_have <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      w_have <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && !w_have) begin
      w_have <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_wr) begin
      w_have <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= QLCD_RESP_OKAY;
    end else if (do_wr) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? QLCD_RESP_OKAY : QLCD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // Byte-lane writes; slot 3 is the read-only status word
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      for (int i = 0; i < 8; i++) begin
        regs[i] <= 32'h0000_0000;
      end
      regs[1] <= {16'h0000, QLCD_ACTIVE_RST};
      regs[2] <= {16'h0000, QLCD_DEAD_RST};
    end else if (do_wr && wr_hit) begin
      for (int b = 0; b < 4; b++) begin
        if (w_strb[b]) begin
          regs[aw_addr[4:2]][b*8 +: 8] <= w_data[b*8 +: 8];
        end
      end
    end
  end

  always_comb begin
    rd_hit = s_axi_araddr[5:2] < 4'h8;
    case (s_axi_araddr[5:2])
      4'h0: rd_val = {29'h0000_0000, regs[0][2:0]};
      4'h1: rd_val = {16'h0000, regs[1][15:0]};
      4'h2: rd_val = {16'h0000, regs[2][15:0]};
      4'h3: rd_val = {24'h00_0000, status};
      4'h4, 4'h5, 4'h6, 4'h7: rd_val = regs[s_axi_araddr[4:2]];
      default: rd_val = 32'h0000_0000;
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= QLCD_RESP_OKAY;
    end else if (s_axi_arvalid && !s_axi_rvalid) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? QLCD_RESP_OKAY : QLCD_RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  always_comb begin
    cfg.enable = regs[0][QLCD_CTRL_EN_BIT];
    cfg.rms_increase = regs[0][QLCD_CTRL_INC_BIT];
    cfg.dead_at_frame_end = regs[0][QLCD_CTRL_EOF_BIT];
    cfg.active_len = regs[1][15:0];
    cfg.dead_len = regs[2][15:0];
    cfg.seg_data = {regs[7], regs[6], regs[5], regs[4]};
  end
endmodule : qlcd_axil_regs

//--- rtl/qlcd_wave_seq.sv
// Quadruplex LCD waveform sequencer top: four-phase frame with active and dead intervals
//
// The address map and the AXI4-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/100ps
module qlcd_wave_seq
  import qlcd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [qlcd_pkg::QLCD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [qlcd_pkg::QLCD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [qlcd_pkg::QLCD_SEGS-1:0] seg_out,
  output logic [qlcd_pkg::QLCD_COMS-1:0] com_out,
  output logic [qlcd_pkg::QLCD_COMS-1:0] com_oe
);
  import qlcd_pkg::*;

  qlcd_cfg_t cfg;
  qlcd_cfg_t live;
  qlcd_part_t part;
  qlcd_pins_t next_pins;
  logic running;
  logic [1:0] phase;
  logic [15:0] count;
  logic [15:0] part_len;
  logic part_end;
  logic frame_end;
  logic skip_dead;
  logic [QLCD_SEGS-1:0] lit;
  logic [7:0] status;
  logic [7:0] frame_cnt;

  qlcd_axil_regs u_regs (
    .clk(clk),
    .sys_rst(sys_rst),
    .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb),
    .s_axi_wvalid(s_axi_wvalid),
    .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_bvalid(s_axi_bvalid),
    .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr),
    .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp),
    .s_axi_rvalid(s_axi_rvalid),
    .s_axi_rready(s_axi_rready),
    .status(status),
    .cfg(cfg)
  );

  assign status = {frame_cnt[3:0], phase, part};

  // Dead intervals: every part, or only the last one of the frame
  always_comb begin
    skip_dead = 1'b0;
    if (live.dead_len == 16'h0000) begin
      skip_dead = 1'b1;
    end else if (live.dead_at_frame_end) begin
      skip_dead = !(phase == 2'h3 && part == QLCD_ACT2);
    end
  end

  always_comb begin
    case (part)
      QLCD_ACT1, QLCD_ACT2: part_len = live.active_len;
      default: part_len = live.dead_len;
    endcase
  end

  // Zero length ends after one cycle instead of wrapping the counter
  assign part_end = (part_len == 16'h0000) || (count >= part_len - 16'h0001);
  assign frame_end = phase == 2'h3 && (part == QLCD_DEAD2 || (part == QLCD_ACT2 && skip_dead));

  // Interval sequencer: ACT1, DEAD1, ACT2, DEAD2 per phase, four phases
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      running <= 1'b0;
      phase <= 2'h0;
      part <= QLCD_ACT1;
      count <= 16'h0000;
      frame_cnt <= 8'h00;
      live <= '0;
    end else if (!running) begin
      count <= 16'h0000;
      phase <= 2'h0;
      part <= QLCD_ACT1;
      live <= cfg;
      running <= cfg.enable;
    end else if (part_end) begin
      count <= 16'h0000;
      case (part)
        QLCD_ACT1: part <= skip_dead ? QLCD_ACT2 : QLCD_DEAD1;
        QLCD_DEAD1: part <= QLCD_ACT2;
        QLCD_ACT2: begin
          if (!skip_dead) begin
            part <= QLCD_DEAD2;
          end else begin
            part <= QLCD_ACT1;
            phase <= phase + 2'h1;
          end
        end
        default: begin
          part <= QLCD_ACT1;
          phase <= phase + 2'h1;
        end
      endcase
      if (frame_end) begin
        live <= cfg;
        running <= cfg.enable;
        frame_cnt <= frame_cnt + 8'h01;
      end
    end else begin
      count <= count + 16'h0001;
    end
  end

  // Segment line s serves four segments; lit bit for common n is at seg_data[n*32+s]
  genvar s;
  generate
    for (s = 0; s < QLCD_SEGS; s++) begin : g_seg
      assign lit[s] = live.seg_data[{phase, 5'h00} + s];
    end
  endgenerate

  always_comb begin
    next_pins.seg = '0;
    next_pins.com_out = '0;
    next_pins.com_oe = '1;
    if (running) begin
      case (part)
        QLCD_ACT1: begin
          next_pins.seg = lit;
          next_pins.com_oe = QLCD_COMS'(4'h1 << phase);
          next_pins.com_out = '0;
        end
        QLCD_ACT2: begin
          next_pins.seg = ~lit;
          next_pins.com_oe = QLCD_COMS'(4'h1 << phase);
          next_pins.com_out = QLCD_COMS'(4'h1 << phase);
        end
        QLCD_DEAD1: begin
          next_pins.seg = live.rms_increase ? '1 : '0;
          next_pins.com_out = '0;
        end
        default: begin
          next_pins.seg = '0;
          next_pins.com_out = live.rms_increase ? '1 : '0;
        end
      endcase
    end
  end

  // Registered pins keep outputs glitch-free across interval changes
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      seg_out <= '0;
      com_out <= '0;
      com_oe <= '1;
    end else begin
      seg_out <= next_pins.seg;
      com_out <= next_pins.com_out;
      com_oe <= next_pins.com_oe;
    end
  end
endmodule : qlcd_wave_seq

//--- bench/qlcd_wave_seq_monitor.sv
// Checker for the quadruplex LCD sequencer pins and bus handshakes
`timescale 1ns/100ps
module qlcd_wave_seq_monitor
  import qlcd_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [qlcd_pkg::QLCD_SEGS-1:0] seg_out,
  input wire logic [qlcd_pkg::QLCD_COMS-1:0] com_out,
  input wire logic [qlcd_pkg::QLCD_COMS-1:0] com_oe
);
  import qlcd_pkg::*;
  logic [QLCD_COMS-1:0] last_oe;
  logic [QLCD_SEGS-1:0] seg_act1;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      last_oe <= '0;
    end else if ($onehot(com_oe)) begin
      last_oe <= com_oe;
    end
  end
  // Only meaningful once a first active interval was seen
  always_ff @(posedge clk) begin
    if ($onehot(com_oe) && (com_out & com_oe) == '0) begin
      seg_act1 <= seg_out;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence wr_both;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_ONE_ACTIVE: assert property (com_oe != '1 |-> $onehot(com_oe))
    else $error("more than one common driven");
  AST_PHASE_ORDER: assert property ($onehot(com_oe) && com_oe != last_oe |->
    com_oe == ((last_oe == '0) ? 4'h1 : {last_oe[QLCD_COMS-2:0], last_oe[QLCD_COMS-1]}))
    else $error("phase order broken");
  AST_INVERT: assert property ($onehot(com_oe) && (com_out & com_oe) != '0 |-> seg_out == ~seg_act1)
    else $error("second active segments not inverted");
  AST_DEAD2: assert property (com_oe == '1 && com_out == '1 |-> seg_out == '0)
    else $error("dead with high commons has lit segments");
  AST_DEAD_LEVELS: assert property (com_oe == '1 |-> (com_out == '0 || com_out == '1) &&
    (seg_out == '0 || seg_out == '1))
    else $error("mixed levels in dead interval");
  AST_RESET_PINS: assert property (disable iff (1'h0) sys_rst |=> seg_out == '0 && com_out == '0 && com_oe == '1)
    else $error("pins not low after reset");
  AST_WR_RESP: assert property (wr_both |-> ##[1:2] s_axi_bvalid)
    else $error("write response missing");
  AST_RD_RESP: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read response missing");
  AST_RD_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped before taken");
endmodule : qlcd_wave_seq_monitor
bind qlcd_wave_seq qlcd_wave_seq_monitor u_mon (.clk(clk), .sys_rst(sys_rst), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .seg_out(seg_out), .com_out(com_out), .com_oe(com_oe));

//--- bench/qlcd_glass.sv
// Glass model: each common settles low, mid or high through its resistor pair
`timescale 1ns/100ps
module qlcd_glass
  import qlcd_pkg::*;
(
  input wire logic [qlcd_pkg::QLCD_COMS-1:0] com_out,
  input wire logic [qlcd_pkg::QLCD_COMS-1:0] com_oe,
  output logic [2*qlcd_pkg::QLCD_COMS-1:0] com_lvl
);
  import qlcd_pkg::*;
  // Level 1 is half supply; a released pin never shows its last drive
  always_comb begin
    for (int i = 0; i < QLCD_COMS; i++) begin
      com_lvl[2*i+:2] = com_oe[i] ? (com_out[i] ? 2'h2 : 2'h0) : 2'h1;
    end
  end
endmodule : qlcd_glass

//--- bench/tb_top.sv
// Testbench for the quadruplex LCD sequencer: bus access and frame waveforms
`timescale 1ns/100ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin errors++; $display("unexpected %s expected %h seen %h", n, e, g); end end
`define WAITC(c) while (!(c)) begin @(posedge clk); #1; end
module tb_top;
  import qlcd_pkg::*;
  localparam logic [15:0] ACT_LEN = 16'h0004;
  localparam logic [15:0] DEAD_LEN = 16'h0003;
  logic clk = 1'h0;
  logic sys_rst = 1'h1;
  logic [5:0] awaddr = '0, araddr = '0;
  logic [31:0] wdata = '0, rdata, rd;
  logic [3:0] wstrb = 4'hF, strb = 4'hF;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, r;
  logic [QLCD_SEGS-1:0] seg_out;
  logic [QLCD_COMS-1:0] com_out, com_oe;
  logic [2*QLCD_COMS-1:0] com_lvl;
  int errors = 0, tests_run = 0;
  always #2 clk = ~clk;
  qlcd_wave_seq dut (.clk(clk), .sys_rst(sys_rst), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .seg_out(seg_out),
    .com_out(com_out), .com_oe(com_oe));
  qlcd_glass u_glass (.com_out(com_out), .com_oe(com_oe), .com_lvl(com_lvl));
  function automatic logic [31:0] seg_word(input int p);
    return 32'hC3A5_0F01 ^ (32'h1111_1111 << p);
  endfunction : seg_word
  // Handshakes sampled at the falling edge so the rising edge acts without a race
  task automatic axi_write(input logic [5:0] a, input logic [31:0] d, output logic [1:0] resp);
    logic ta, tw, tb;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    wstrb <= strb;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(negedge clk);
      ta = awvalid && awready;
      tw = wvalid && wready;
      tb = bvalid && bready;
      resp = bresp;
      @(posedge clk);
      if (ta) awvalid <= 1'h0;
      if (tw) wvalid <= 1'h0;
      if (tb) bready <= 1'h0;
    end while (!tb);
  endtask : axi_write
  // Ready raised late on purpose so read data must stand
  task automatic axi_read(input logic [5:0] a, output logic [31:0] d, output logic [1:0] resp);
    logic ta, tv, tr;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'h1;
    do begin
      @(negedge clk);
      ta = arvalid && arready;
      tv = rvalid && !rready;
      tr = rvalid && rready;
      d = rdata;
      resp = rresp;
      @(posedge clk);
      if (ta) arvalid <= 1'h0;
      if (tv) rready <= 1'h1;
      if (tr) rready <= 1'h0;
    end while (!tr);
  endtask : axi_read
  task automatic test_regs;
    axi_read(QLCD_ACTIVE_OFS, rd, r);
    `CHK("active reset", {16'h0000, QLCD_ACTIVE_RST}, rd)
    axi_read(6'h20, rd, r);
    `CHK("unmapped resp", QLCD_RESP_SLVERR, r)
    axi_write(QLCD_STATUS_OFS, 32'hFFFF_FFFF, r);
    `CHK("status write resp", QLCD_RESP_SLVERR, r)
    axi_write(QLCD_ACTIVE_OFS, {16'h0000, ACT_LEN}, r);
    axi_write(QLCD_DEAD_OFS, {16'h0000, DEAD_LEN}, r);
    // Only byte lane 1 may change
    strb = 4'h2;
    axi_write(QLCD_DEAD_OFS, 32'hFFFF_FFFF, r);
    axi_read(QLCD_DEAD_OFS, rd, r);
    `CHK("dead lane", {16'h0000, 8'hFF, DEAD_LEN[7:0]}, rd)
    axi_write(QLCD_DEAD_OFS, 32'h0000_0000, r);
    strb = 4'hF;
    for (int p = 0; p < QLCD_COMS; p++) axi_write(QLCD_SEG0_OFS + 6'(4 * p), seg_word(p), r);
    axi_read(QLCD_DEAD_OFS, rd, r);
    `CHK("dead len", {16'h0000, DEAD_LEN}, rd)
    $display("test regs done");
  endtask : test_regs
  task automatic dead_run(input logic [QLCD_SEGS-1:0] s, input logic [3:0] co);
    int n;
    n = 0;
    while (com_oe == 4'hF) begin
      `CHK("dead pins", {s, co}, {seg_out, com_out})
      n++;
      @(posedge clk);
      #1;
    end
    `CHK("dead length", DEAD_LEN, 16'(n))
  endtask : dead_run
  task automatic act_run(input int p, input logic hi);
    int n;
    n = 0;
    while (com_oe == 4'(1 << p) && com_out[p] == hi) begin
      n++;
      @(posedge clk);
      #1;
    end
    `CHK("active length", ACT_LEN, 16'(n))
  endtask : act_run
  task automatic check_frame(input logic [2:0] c);
    for (int p = 0; p < QLCD_COMS; p++) begin
      `WAITC(com_oe == 4'(1 << p) && com_out[p] == 1'h0)
      `CHK("act1 seg", seg_word(p), seg_out)
      for (int q = 0; q < QLCD_COMS; q++) if (q != p) `CHK("idle com", 2'h1, com_lvl[2*q+:2])
      act_run(p, 1'h0);
      if (!c[2]) begin
        `WAITC(com_oe == 4'hF)
        dead_run({QLCD_SEGS{c[1]}}, 4'h0);
      end
      `WAITC(com_oe == 4'(1 << p) && com_out[p] == 1'h1)
      `CHK("act2 seg", ~seg_word(p), seg_out)
      act_run(p, 1'h1);
      if (!c[2] || p == 3) begin
        `WAITC(com_oe == 4'hF)
        dead_run('0, {4{c[1]}});
      end
    end
  endtask : check_frame
  // New settings only show from the next whole frame
  task automatic test_mode(input logic [2:0] c);
    axi_write(QLCD_CTRL_OFS, {29'h0, c}, r);
    `CHK("ctrl resp", QLCD_RESP_OKAY, r)
    `WAITC(com_oe == 4'h8)
    `WAITC(com_oe == 4'h1)
    check_frame(c);
    $display("test mode %0d done", c);
  endtask : test_mode
  task automatic test_stop;
    axi_write(QLCD_CTRL_OFS, 32'h0, r);
    `WAITC(com_oe == 4'h8)
    `WAITC(com_oe == 4'hF)
    repeat (80) begin
      @(posedge clk);
      #1;
      `CHK("stopped pins", {36'h0, 4'hF}, {seg_out, com_out, com_oe})
    end
    axi_read(QLCD_STATUS_OFS, rd, r);
    `CHK("status idle", 4'h0, rd[3:0])
    `CHK("status resp", QLCD_RESP_OKAY, r)
    $display("test stop done");
  endtask : test_stop
  task automatic final_report;
    $display("checks %0d errors %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : final_report
  initial begin
    repeat (10) @(posedge clk);
    sys_rst <= 1'h0;
    @(posedge clk);
    #1;
    `CHK("reset pins", {36'h0, 4'hF}, {seg_out, com_out, com_oe})
    test_regs;
    test_mode(3'h1);
    test_mode(3'h3);
    test_mode(3'h7);
    test_mode(3'h5);
    test_stop;
    final_report;
  end
  initial begin
    #20000;
    errors++;
    final_report;
  end
endmodule : tb_top
